// ==== logic/ctu_pkg.sv ====
/*
 * Constants for the charge time unit edge control block: register map,
 * control bit positions, reset values and status word layout.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package ctu_pkg;
    localparam int unsigned ADDR_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ONE_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h04;

    // Control register field positions
    localparam int unsigned UNIT_ENABLE_BIT   = 15;
    localparam int unsigned IDLE_STOP_BIT     = 13;
    localparam int unsigned DELAY_GEN_BIT     = 12;
    localparam int unsigned EDGE_SRC_BIT      = 11;
    localparam int unsigned EDGE_ORDER_BIT    = 10;
    localparam int unsigned SRC_GROUND_BIT    = 9;
    localparam int unsigned CONV_TRIG_BIT     = 8;

    // Writable bits: 15, 13..8; bit 14 and the low byte stay zero
    localparam logic [15:0] CTRL_ONE_WMASK = 16'hBF00;
    localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;

    // Status register field positions
    localparam int unsigned ST_ACTIVE_BIT   = 0;
    localparam int unsigned ST_EDGE1_BIT    = 1;
    localparam int unsigned ST_EDGE2_BIT    = 2;
    localparam int unsigned ST_DELAY_BIT    = 3;
    localparam int unsigned ST_GROUND_BIT   = 4;

    // Edge tracking states
    typedef enum logic [2:0] {
        CTU_WAIT_E1 = 3'b001,
        CTU_WAIT_E2 = 3'b010,
        CTU_DONE    = 3'b100
    } ctu_edge_state_t;
endpackage : ctu_pkg

// ==== logic/ctu_sync.sv ====
/*
 * Two-flop synchroniser for a bus of asynchronous levels.
 * Assumes the inputs are levels held much longer than a clock period.
 */
`timescale 1ns/1ns
module ctu_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : ctu_sync

// ==== logic/ctu_edge_ctrl.sv ====
/*
 * Charge time unit control: the first control register on APB, edge
 * capture and ordering, delay generation gate, converter trigger and
 * current source ground control.
 * Assumes the edge input pins arrive asynchronously, timer sources and
 * the idle request come from logic on clk_i.
 */
// How it works
// - Edge capture, delay and trigger work only while the enable bit 15 is one.
// - With idle stop set, the unit halts while the device is idle.
// - Bit 12 turns edge delay generation on or off.
// - Bit 11 picks hardware edge sources; zero means software sets edge flags.
// - With bit 10 set, edge 2 counts only with or after edge 1.
// - Bit 9 grounds the analog current source output.
// - Bit 8 lets the unit trigger a converter start of conversion.
// - Bit 14 and the low byte read zero and ignore writes.
`timescale 1ns/1ns
module ctu_edge_ctrl #(
    parameter int unsigned EDGE_PINS = 2
) (
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    // APB slave
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [ctu_pkg::ADDR_W-1:0]   paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    input  wire logic [3:0]                   pstrb_i,
    output logic      [31:0]                  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    // Device and edge sources
    input  wire logic                         idle_i,
    input  wire logic [1:0]                   timer_source_i,
    input  wire logic [EDGE_PINS-1:0]         edge_input_pin_i,
    input  wire logic [1:0]                   edge_status_flag_set_i,
    input  wire logic [1:0]                   edge_status_flag_clr_i,
    // Outputs to current source and converter
    output logic                              delay_active_o,
    output logic                              source_ground_o,
    output logic                              conv_start_o,
    output logic [1:0]                        edge_status_flag_o
);
    import ctu_pkg::*;

    logic [15:0]          ctrl_q;
    logic [1:0]           edge_q;
    logic [EDGE_PINS-1:0] pin_sync;
    logic [1:0]           hw_q;
    logic [1:0]           hw_rise;
    logic [1:0]           edge_ev;
    logic                 running;
    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_ok;
    logic [1:0]           edge_d;
    logic                 trig_fire;
    logic [31:0]          rdata_d;
    ctu_edge_state_t      state_q;

    ctu_sync #(
        .WIDTH (EDGE_PINS)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i (edge_input_pin_i),
        .sync_o  (pin_sync)
    );

    // Single-cycle access phase: no wait states
    assign pready_o  = 1'b1;
    assign addr_ok   = (paddr_i == CTRL_ONE_OFS) || (paddr_i == STATUS_OFS);
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign wr_en     = psel_i && penable_i && pwrite_i && (paddr_i == CTRL_ONE_OFS);
    assign rd_en     = psel_i && !penable_i && !pwrite_i;

    assign running = ctrl_q[UNIT_ENABLE_BIT] && !(ctrl_q[IDLE_STOP_BIT] && idle_i);

    // Control register: only implemented bits take writes, byte lanes honoured
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= CTRL_ONE_RESET;
        end else if (wr_en) begin
            for (int i = 0; i < 2; i++) begin
                if (pstrb_i[i]) begin
                    ctrl_q[i*8 +: 8] <= pwdata_i[i*8 +: 8] & CTRL_ONE_WMASK[i*8 +: 8];
                end
            end
        end
    end

    // Hardware source: timer level or synchronised pin, rising edge detected
    // A level already high when hardware sources are picked does not count as an edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hw_q <= 2'b00;
        end else begin
            hw_q <= timer_source_i | pin_sync[1:0];
        end
    end

    assign hw_rise = (timer_source_i | pin_sync[1:0]) & ~hw_q;

    always_comb begin
        if (ctrl_q[EDGE_SRC_BIT]) begin
            edge_ev = hw_rise;
        end else begin
            edge_ev = edge_status_flag_set_i;
        end
        // Disabled or stopped in idle: nothing is accepted
        if (!running) begin
            edge_ev = 2'b00;
        end
        // Edge 2 waits for edge 1, flagged earlier or arriving in the same cycle
        if (ctrl_q[EDGE_ORDER_BIT] && !edge_q[0] && !edge_ev[0]) begin
            edge_ev[1] = 1'b0;
        end
    end

    // Edge flags: a new edge wins over a same-cycle clear
    assign edge_d = (edge_q & ~edge_status_flag_clr_i) | edge_ev;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            edge_q <= 2'b00;
        end else begin
            edge_q <= edge_d;
        end
    end

    // Edge sequence tracker, used for the delay window and trigger
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= CTU_WAIT_E1;
        end else if (!ctrl_q[UNIT_ENABLE_BIT]) begin
            state_q <= CTU_WAIT_E1;
        end else begin
            unique case (state_q)
                CTU_WAIT_E1: begin
                    if (edge_ev[0] && edge_ev[1]) begin
                        state_q <= CTU_DONE;
                    end else if (edge_ev[0]) begin
                        state_q <= CTU_WAIT_E2;
                    end
                end
                CTU_WAIT_E2: begin
                    if (edge_ev[1]) begin
                        state_q <= CTU_DONE;
                    end else if (edge_q == 2'b00 && edge_ev == 2'b00) begin
                        // Flags cleared mid-sequence: drop it so no stale delay window stays open
                        state_q <= CTU_WAIT_E1;
                    end
                end
                CTU_DONE: begin
                    if (edge_q == 2'b00) begin
                        state_q <= CTU_WAIT_E1;
                    end
                end
                default: begin
                    state_q <= CTU_WAIT_E1;
                end
            endcase
        end
    end

    // Trigger on each accepted edge 2 until the sequence is done, including one that comes before edge 1
    assign trig_fire = running && ctrl_q[CONV_TRIG_BIT] && (state_q != CTU_DONE) && edge_ev[1];

    // Outputs registered so the analog side sees clean levels
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            delay_active_o <= 1'b0;
        end else begin
            delay_active_o <= running && ctrl_q[DELAY_GEN_BIT] && (state_q == CTU_WAIT_E2);
        end
    end

    // Ground follows the bit even while disabled; the converter must be sampling meanwhile
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            source_ground_o <= 1'b0;
        end else begin
            source_ground_o <= ctrl_q[SRC_GROUND_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= trig_fire;
        end
    end

    assign edge_status_flag_o = edge_q;

    // Read mux; anything outside the map reads zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (paddr_i == CTRL_ONE_OFS) begin
            rdata_d[15:0] = ctrl_q & CTRL_ONE_WMASK;
        end else if (paddr_i == STATUS_OFS) begin
            rdata_d[ST_ACTIVE_BIT] = running;
            rdata_d[ST_EDGE1_BIT]  = edge_q[0];
            rdata_d[ST_EDGE2_BIT]  = edge_q[1];
            rdata_d[ST_DELAY_BIT]  = delay_active_o;
            rdata_d[ST_GROUND_BIT] = source_ground_o;
        end
    end

    // Read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_o <= rdata_d;
        end
    end
endmodule : ctu_edge_ctrl

// ==== sim/ctu_edge_ctrl_properties.sv ====
/* Port checker for ctu_edge_ctrl.
   Assumes one clock domain and an async high reset. */
`timescale 1ns/1ns
module ctu_edge_ctrl_chk import ctu_pkg::*; (
    input wire logic              clk_i,
    input wire logic              reset_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              delay_active_o,
    input wire logic              source_ground_o,
    input wire logic              conv_start_o,
    input wire logic [1:0]        edge_status_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic acc;
    logic wg;
    assign acc = psel_i && penable_i;
    assign wg = acc && pwrite_i && paddr_i == CTRL_ONE_OFS && pstrb_i[1] && pwdata_i[9];
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_ground_set: assert property (wg |-> ##[1:2] source_ground_o) else $error("ground late");
    a_ground_cause: assert property ($rose(source_ground_o) |-> $past(wg) || $past(wg, 2))
        else $error("ground rose alone");
    a_reset_quiet: assert property ($past(reset_i) |-> !source_ground_o && !conv_start_o
        && !delay_active_o && edge_status_flag_o == 2'b00) else $error("not quiet");
    a_trig_pulse: assert property (conv_start_o |=> !conv_start_o) else $error("long trigger");
    a_trig_edge: assert property (conv_start_o |-> edge_status_flag_o[1]) else $error("early trigger");
    a_read_zero: assert property (acc && !pwrite_i && paddr_i == CTRL_ONE_OFS |->
        prdata_o[31:16] == 16'h0000 && !prdata_o[14] && prdata_o[7:0] == 8'h00)
        else $error("unimplemented bit set");
    a_err_unmapped: assert property (acc |-> pslverr_o == (paddr_i != CTRL_ONE_OFS && paddr_i != STATUS_OFS))
        else $error("pslverr wrong");
    a_delay_edge: assert property ($rose(delay_active_o) |-> ##[0:1] edge_status_flag_o[0])
        else $error("delay without edge");
endmodule : ctu_edge_ctrl_chk
bind ctu_edge_ctrl ctu_edge_ctrl_chk chk_u (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .delay_active_o, .source_ground_o,
    .conv_start_o, .edge_status_flag_o);

// ==== sim/ctu_adc_model.sv ====
/* Converter model: counts start pulses.
   Assumes pulses and ground level on clk_i. */
`timescale 1ns/1ns
module ctu_adc_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       conv_start_i,
    input  wire logic       source_ground_i,
    output logic            sampling_o,
    output logic [7:0]      conv_count_o
);
    // Stays sampling while the sink is grounded
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) sampling_o <= 1'b0;
        else sampling_o <= source_ground_i || (sampling_o && !conv_start_i);
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) conv_count_o <= 8'h00;
        else if (conv_start_i) conv_count_o <= conv_count_o + 8'h01;
    end
endmodule : ctu_adc_model

// ==== sim/charge_time_edge_control_test.sv ====
/* Bench for ctu_edge_ctrl: APB master and edge scenarios.
   Assumes a 10 MHz clock. */
`timescale 1ns/1ns
module charge_time_edge_control_test;
    import ctu_pkg::*;
    logic        clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, idle_i = 0, err;
    logic [7:0]  paddr_i = 8'h00, convs, n0;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic [1:0]  tmr = 2'b00, set_i = 2'b00, clr_i = 2'b00, flg, pin = 2'b00;
    logic        pready_o, pslverr_o, dly, gnd, conv, smp;
    int          miscompares = 0, checks = 0, cycles = 0;
    always #50 clk_i = ~clk_i;
    ctu_edge_ctrl dut_u (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i(4'hF), .prdata_o, .pready_o, .pslverr_o, .idle_i, .timer_source_i(tmr),
        .edge_input_pin_i(pin), .edge_status_flag_set_i(set_i), .edge_status_flag_clr_i(clr_i),
        .delay_active_o(dly), .source_ground_o(gnd), .conv_start_o(conv), .edge_status_flag_o(flg));
    ctu_adc_model adc_u (.clk_i, .reset_i, .conv_start_i(conv), .source_ground_i(gnd),
        .sampling_o(smp), .conv_count_o(convs));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // Flags are cleared before the write so a new mode never starts mid-sequence
    task automatic setc(input logic [15:0] c);
        clr_i <= 2'b11;
        @(posedge clk_i);
        clr_i <= 2'b00;
        apb(1'b1, CTRL_ONE_OFS, {16'h0000, c});
    endtask : setc
    // One-cycle edge, then time for the delay output and trigger to settle
    task automatic pulse(input logic hw, input logic [1:0] s);
        if (hw) tmr <= s;
        else set_i <= s;
        @(posedge clk_i);
        tmr <= 2'b00;
        set_i <= 2'b00;
        repeat (4) @(posedge clk_i);
    endtask : pulse
    task automatic t_regs;
        apb(1'b0, CTRL_ONE_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "ctrl reset");
        apb(1'b1, CTRL_ONE_OFS, 32'hFFFF_FFFF);
        apb(1'b0, CTRL_ONE_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_BF00, "ctrl mask");
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({rd[31:1], err}, 32'h0000_0001, "unmapped");
    endtask : t_regs
    task automatic t_ground;
        setc(16'h0000);
        repeat (2) @(posedge clk_i);
        chk(gnd, 0, "ground off");
        setc(16'h0200);
        repeat (3) @(posedge clk_i);
        chk(gnd, 1, "ground on");
        chk(smp, 1, "sampling while grounded");
    endtask : t_ground
    task automatic t_soft;
        pulse(1'b0, 2'b01);
        chk(flg, 0, "disabled");
        setc(16'h8100);
        n0 = convs;
        pulse(1'b1, 2'b01);
        chk(flg, 0, "timer in soft mode");
        pulse(1'b0, 2'b01);
        pulse(1'b0, 2'b10);
        chk(flg, 3, "soft edges");
        chk(convs, n0 + 8'h01, "trigger");
        setc(16'h8000);
        pulse(1'b0, 2'b01);
        pulse(1'b0, 2'b10);
        chk(convs, n0 + 8'h01, "no trigger");
    endtask : t_soft
    task automatic t_order;
        setc(16'h8C00);
        pulse(1'b1, 2'b10);
        chk(flg, 0, "edge2 first");
        pulse(1'b1, 2'b01);
        pulse(1'b1, 2'b10);
        chk(flg, 3, "hw edges");
        setc(16'h8800);
        pulse(1'b1, 2'b10);
        chk(flg, 2, "no order");
        setc(16'h8800);
        pin <= 2'b01;
        repeat (6) @(posedge clk_i);
        pin <= 2'b00;
        chk(flg, 1, "pin edge");
    endtask : t_order
    task automatic t_idle;
        idle_i <= 1'b1;
        setc(16'hA000);
        pulse(1'b0, 2'b01);
        chk(flg, 0, "idle stop");
        setc(16'h8000);
        pulse(1'b0, 2'b01);
        chk(flg, 1, "idle run");
        idle_i <= 1'b0;
    endtask : t_idle
    task automatic t_delay;
        setc(16'h9000);
        pulse(1'b0, 2'b01);
        chk(dly, 1, "delay on");
        apb(1'b0, STATUS_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_000B, "status");
        pulse(1'b0, 2'b10);
        chk(dly, 0, "delay end");
        setc(16'h8000);
        pulse(1'b0, 2'b01);
        chk(dly, 0, "delay off");
    endtask : t_delay
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs;
        t_ground;
        t_soft;
        t_order;
        t_idle;
        t_delay;
        wrap_up;
    end
    always @(posedge clk_i) begin
        if (++cycles > 3000) begin
            miscompares++;
            wrap_up;
        end
    end
endmodule : charge_time_edge_control_test
